// ===== core/omd_pkg.sv
// Package for the OR / move execution slice.
// Assumes an upstream decode stage that hands over one decoded instruction per cycle.
package omd_pkg;

    // ------------------------------------------------------------
    // Widths, reset values and destination codes
    // ------------------------------------------------------------
    localparam int          DATA_W      = 8;
    localparam int          ADDR_W      = 7;
    localparam int          FILE_DEPTH  = 128;
    localparam logic [7:0]  ACCUM_RST   = 8'h00;
    localparam logic        ZERO_RST    = 1'b0;
    localparam logic        DEST_ACCUM  = 1'b0;
    localparam logic        DEST_FILE   = 1'b1;

    // ------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OMD_IDLE_INSTRUCTION,
        OMD_OR_LITERAL,
        OMD_LOAD_LITERAL,
        OMD_OR_ACCUM_INTO_REG,
        OMD_STORE_ACCUM,
        OMD_COPY_REG
    } omd_op_t;

    typedef struct packed {
        omd_op_t            op;
        logic [ADDR_W-1:0]  addr;
        logic               dest;
        logic [DATA_W-1:0]  literal;
    } omd_instr_t;

    typedef struct packed {
        logic               valid;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  data;
    } omd_wr_t;

endpackage : omd_pkg

// ===== core/omd_core.sv
// Execution slice: accumulator, zero flag and a 128-entry file register array.
// Assumes decode presents one instruction per clock with instr_valid_i.
`timescale 1ns/1ns

// Notes on behaviour
// (RULE_01) OR literal into accumulator, update zero
// (RULE_02) Load literal to accumulator, flags untouched
// (RULE_03) Unused literal bits arrive as zero
// (RULE_04) OR accumulator with addressed file register, zero
// (RULE_05) Destination bit picks accumulator or register
// (RULE_06) Copy register to accumulator or itself
// (RULE_07) Self copy still updates zero flag
// (RULE_08) Store and idle leave flags untouched
module omd_core
    import omd_pkg::*;
#(
    parameter int DEPTH = omd_pkg::FILE_DEPTH
)(
    input  wire logic                    clock_i,
    input  wire logic                    nrst_i,
    input  wire logic                    instr_valid_i,
    input  wire omd_pkg::omd_instr_t     instr_i,
    output logic [omd_pkg::DATA_W-1:0]   accum_o,
    output logic                         zero_o,
    output omd_pkg::omd_wr_t             file_wr_o
);
    import omd_pkg::*;

    // Elaboration check: the 7-bit address reaches at most FILE_DEPTH entries
    if (DEPTH < 1 || DEPTH > FILE_DEPTH)
    begin : g_depth_check
        $error("DEPTH must be 1..128");
    end

    logic [DATA_W-1:0] accum_reg;
    logic              zero_reg;
    omd_wr_t           wr_reg;
    logic [DATA_W-1:0] file_mem [DEPTH];
    logic [DATA_W-1:0] file_rd;
    logic [DATA_W-1:0] result;
    logic              to_file;
    logic              to_accum;
    logic              sets_zero;

    // ------------------------------------------------------------
    // File read port
    // ------------------------------------------------------------
    // Addresses beyond DEPTH read as zero
    assign file_rd = (int'(instr_i.addr) < DEPTH) ? file_mem[instr_i.addr] : '0;

    // ------------------------------------------------------------
    // Result and destination decode
    // ------------------------------------------------------------
    always_comb
    begin
        result    = '0;
        to_file   = 1'b0;
        to_accum  = 1'b0;
        sets_zero = 1'b0;
        if (instr_valid_i)
        begin
            case (instr_i.op)
                // (RULE_01) literal OR path
                OMD_OR_LITERAL:
                begin
                    result    = accum_reg | instr_i.literal;
                    to_accum  = 1'b1;
                    sets_zero = 1'b1;
                end
                // (RULE_02) plain load, no flag
                OMD_LOAD_LITERAL:
                begin
                    result   = instr_i.literal;
                    to_accum = 1'b1;
                end
                // (RULE_04) register OR, (RULE_05) destination select
                OMD_OR_ACCUM_INTO_REG:
                begin
                    result    = accum_reg | file_rd;
                    to_accum  = (instr_i.dest == DEST_ACCUM);
                    to_file   = (instr_i.dest == DEST_FILE);
                    sets_zero = 1'b1;
                end
                // (RULE_06) copy, (RULE_07) self rewrite keeps zero update
                OMD_COPY_REG:
                begin
                    result    = file_rd;
                    to_accum  = (instr_i.dest == DEST_ACCUM);
                    to_file   = (instr_i.dest == DEST_FILE);
                    sets_zero = 1'b1;
                end
                // (RULE_08) store without flag change
                OMD_STORE_ACCUM:
                begin
                    result  = accum_reg;
                    to_file = 1'b1;
                end
                // (RULE_08) idle changes nothing
                OMD_IDLE_INSTRUCTION:
                begin
                    result = '0;
                end
                default:
                begin
                    result = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Accumulator and zero flag
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
            accum_reg <= ACCUM_RST;
        else if (to_accum)
            accum_reg <= result;
    end

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
            zero_reg <= ZERO_RST;
        else if (sets_zero)
            zero_reg <= (result == '0);
    end

    // ------------------------------------------------------------
    // File registers
    // ------------------------------------------------------------
    // Array not reset; contents are software state like real RAM
    always_ff @(posedge clock_i)
    begin
        if (nrst_i && to_file && int'(instr_i.addr) < DEPTH)
            file_mem[instr_i.addr] <= result;
    end

    // Write echo lets the outside see each file write
    // Quiet cycles show all zero, so no stale data leaks out
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i || !to_file)
            wr_reg <= '0;
        else
            wr_reg <= '{valid: 1'b1, addr: instr_i.addr, data: result};
    end

    assign accum_o   = accum_reg;
    assign zero_o    = zero_reg;
    assign file_wr_o = wr_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Expected values rebuilt from past inputs, never from result
    sequence s_op(omd_op_t o);
        instr_valid_i && instr_i.op == o;
    endsequence

    sequence s_op_dest(omd_op_t o, logic d);
        instr_valid_i && instr_i.op == o && instr_i.dest == d;
    endsequence

    a_or_literal_result: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_01
        s_op(OMD_OR_LITERAL) |=> accum_o == ($past(accum_o) | $past(instr_i.literal))
            && zero_o == (($past(accum_o) | $past(instr_i.literal)) == 8'h00))
        else $error("or literal result wrong");

    a_load_keeps_flag: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_02
        s_op(OMD_LOAD_LITERAL) |=> accum_o == $past(instr_i.literal) && $stable(zero_o))
        else $error("load literal wrong");

    a_or_reg_zero: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_04
        s_op(OMD_OR_ACCUM_INTO_REG) |=> zero_o == (($past(accum_o) | $past(file_rd)) == 8'h00))
        else $error("or register zero flag wrong");

    a_or_reg_dest: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_05
        s_op_dest(OMD_OR_ACCUM_INTO_REG, DEST_FILE) |=> file_wr_o.valid && $stable(accum_o)
            && file_wr_o.addr == $past(instr_i.addr)
            && file_wr_o.data == ($past(accum_o) | $past(file_rd)))
        else $error("or register destination wrong");

    a_or_reg_to_accum: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_05
        s_op_dest(OMD_OR_ACCUM_INTO_REG, DEST_ACCUM) |=> !file_wr_o.valid
            && accum_o == ($past(accum_o) | $past(file_rd)))
        else $error("or register to accumulator wrong");

    a_copy_to_accum: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_06
        s_op_dest(OMD_COPY_REG, DEST_ACCUM) |=> accum_o == $past(file_rd) && !file_wr_o.valid)
        else $error("copy to accumulator wrong");

    a_copy_self_test: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_07
        s_op_dest(OMD_COPY_REG, DEST_FILE) |=> file_wr_o.data == $past(file_rd)
            && $stable(accum_o)
            && zero_o == ($past(file_rd) == 8'h00))
        else $error("self copy wrong");

    a_store_no_flag: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_08
        s_op(OMD_STORE_ACCUM) |=> file_wr_o.valid && file_wr_o.data == accum_o && $stable(zero_o))
        else $error("store accumulator wrong");

    a_idle_no_change: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_08
        s_op(OMD_IDLE_INSTRUCTION) |=> $stable(accum_o) && $stable(zero_o) && !file_wr_o.valid)
        else $error("idle instruction changed state");

    a_or_literal_no_write: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_01
        s_op(OMD_OR_LITERAL) |=> !file_wr_o.valid)
        else $error("or literal wrote a register");

    a_load_no_write: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_02
        s_op(OMD_LOAD_LITERAL) |=> !file_wr_o.valid)
        else $error("load literal wrote a register");

    a_copy_accum_zero: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_06
        s_op_dest(OMD_COPY_REG, DEST_ACCUM) |=> zero_o == ($past(file_rd) == 8'h00))
        else $error("copy to accumulator zero flag wrong");

    a_store_keeps_accum: assert property (@(posedge clock_i) disable iff (!nrst_i) // RULE_08
        s_op(OMD_STORE_ACCUM) |=> $stable(accum_o) && file_wr_o.addr == $past(instr_i.addr))
        else $error("store accumulator changed accumulator");

endmodule : omd_core

// ===== verification/omd_core_tb.sv
// Self-checking bench for the OR / move slice: random instruction stream against a bench model.
// Assumes the bench loads every file register before any instruction reads it.
`timescale 1ns/1ns
module omd_core_tb;
    import omd_pkg::*;
    logic               clock_i;
    logic               nrst_i;
    logic               instr_valid_i;
    omd_instr_t         instr_i;
    logic [DATA_W-1:0]  accum_o;
    logic               zero_o;
    omd_wr_t            file_wr_o;
    logic [24:0]        exp_q[$];
    logic [24:0]        got;
    logic [DATA_W-1:0]  mem [FILE_DEPTH];
    logic [DATA_W-1:0]  acc;
    logic               zf;
    logic               taken = 1'b0;
    int                 error_cnt = 0;
    int                 compares = 0;
    int                 seed_val;
    omd_op_t            op;

    omd_core i_omd_core (.clock_i(clock_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i),
                         .instr_i(instr_i), .accum_o(accum_o), .zero_o(zero_o), .file_wr_o(file_wr_o));

    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic finish_test;
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    // Zero literals often, so the zero flag gets set as well as cleared
    function automatic logic [7:0] rnd_k;
        return ($urandom_range(3) == 0) ? 8'h00 : 8'($urandom);
    endfunction : rnd_k

    // ------------------------------------------------------------
    // Driver and model: valid stays high between calls
    // ------------------------------------------------------------
    task automatic issue(input omd_op_t o, input logic [6:0] a, input logic d, input logic [7:0] k);
        logic [DATA_W-1:0] r;
        omd_wr_t           w;
        w = '0;
        case (o)
            OMD_OR_LITERAL:
            begin
                acc = acc | k;
                zf  = (acc == 8'h00);
            end
            OMD_LOAD_LITERAL: acc = k;
            OMD_OR_ACCUM_INTO_REG, OMD_COPY_REG:
            begin
                r  = (o == OMD_COPY_REG) ? mem[a] : (acc | mem[a]);
                zf = (r == 8'h00);
                if (d == DEST_FILE)
                begin
                    w      = '{1'b1, a, r};
                    mem[a] = r;
                end
                else
                    acc = r;
            end
            OMD_STORE_ACCUM:
            begin
                w      = '{1'b1, a, acc};
                mem[a] = acc;
            end
            default: ;
        endcase
        instr_i       = '{o, a, d, k};
        instr_valid_i = 1'b1;
        exp_q.push_back({acc, zf, w});
        @(posedge clock_i);
        #2;
    endtask : issue

    // ------------------------------------------------------------
    // Reset: every edge held in reset yields cleared outputs
    // ------------------------------------------------------------
    task automatic reset_dut(input int n);
        nrst_i        = 1'b0;
        instr_valid_i = 1'b0;
        repeat (n)
        begin
            exp_q.push_back({ACCUM_RST, ZERO_RST, 16'h0000});
            @(posedge clock_i);
            #2;
        end
        nrst_i = 1'b1;
        acc    = ACCUM_RST;
        zf     = ZERO_RST;
    endtask : reset_dut

    // ------------------------------------------------------------
    // Monitor: one note per executed instruction or reset edge
    // ------------------------------------------------------------
    always @(posedge clock_i) taken <= !nrst_i || instr_valid_i;
    always @(negedge clock_i)
        if (taken)
        begin
            got = {accum_o, zero_o, file_wr_o};
            compares++;
            if (got !== exp_q[0])
            begin
                error_cnt++;
                $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp_q[0], got);
            end
            void'(exp_q.pop_front());
        end

    initial
    begin
        #100000;
        error_cnt++;
        finish_test();
    end

    initial
    begin
        instr_i       = '0;
        seed_val      = $urandom(32'h29CBF17D);
        reset_dut(2);
        // Load every register first: the array is not reset
        for (int i = 0; i < FILE_DEPTH; i++)
        begin
            issue(OMD_LOAD_LITERAL, 7'h00, 1'b0, rnd_k());
            issue(OMD_STORE_ACCUM, 7'(i), 1'b0, 8'h00);
        end
        // Back-to-back random mix of every operation
        for (int n = 0; n < 2000; n++)
        begin
            // Mid-run reset: accumulator and flag clear, file array keeps its contents
            if (n == 1000)
                reset_dut(2);
            op = omd_op_t'(3'($urandom_range(5)));
            issue(op, 7'($urandom_range(127)), 1'($urandom),
                  (op == OMD_OR_LITERAL || op == OMD_LOAD_LITERAL) ? rnd_k() : 8'h00);
        end
        instr_valid_i = 1'b0;
        repeat (3) @(posedge clock_i);
        finish_test();
    end
endmodule : omd_core_tb
